// *** inc/sdt_pkg.sv ***
// constants and types for the symbol detector threshold block
// Function
// - meter thresholds are 16-bit signed, pause limit unsigned, low and high bytes
// - pause zeroes predictor correction before subtraction
// - pause lasts five symbols after last exceed
// - predictor coefficient updates continue while paused
// - sync passes when matches exceed 7-bit limit
// - sync limit ignored unless auto sync enabled
// - remote level above high limit sets flag
// - remote level below low limit sets flag
// - noise meter above limit sets low-SNR flag
// - four-level thresholds are zero and twice cursor
// - scaled output is symbol times cursor level
// - self-adapt gain error is abs output minus target
// - equalizer-error mode ignores gain target
// - output select picks receive interface source
// - feedback select picks scrambler or slicer path
// - two-level slicer keeps sign bits only
// - two-level scrambler runs per symbol, magnitude zero
// - four-level scrambler runs per bit, both bits
// - peak path gets programmable extra symbol delay
// - gain mode bit selects equalizer-error or self-adapt
package sdt_pkg;
	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_IRQ_SOURCE = 8'h05;
	localparam logic [7:0] ADDR_PAUSE_LIMIT = 8'h2c;
	localparam logic [7:0] ADDR_SYNC_LIMIT = 8'h2e;
	localparam logic [7:0] ADDR_HIGH_LIMIT = 8'h30;
	localparam logic [7:0] ADDR_LOW_LIMIT = 8'h32;
	localparam logic [7:0] ADDR_NOISE_LIMIT = 8'h34;
	localparam logic [7:0] ADDR_UNIT_LEVEL = 8'h36;
	localparam logic [7:0] ADDR_GAIN_TARGET = 8'h38;
	localparam logic [7:0] ADDR_MODE_CONTROL = 8'h3a;
	localparam logic [7:0] ADDR_PEAK_DELAY = 8'h3b;
	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int PEAK_ENABLE_BIT = 7;
	localparam int OUT_SELECT_LSB = 5;
	localparam int FEEDBACK_SELECT_BIT = 4;
	localparam int TWO_LEVEL_BIT = 3;
	localparam int FLAG_LEVEL_HIGH = 0;
	localparam int FLAG_LEVEL_LOW = 1;
	localparam int FLAG_LOW_SNR = 2;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] PAUSE_SYMBOLS = 3'h5;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {OUT_FOLLOW_FEEDBACK, OUT_TX_LOOPBACK, OUT_SCRAMBLER,
		OUT_RESERVED} sdt_outsel_t;
	typedef struct packed {
		logic sign; // 1 is positive
		logic mag; // 0 is outer level (3), 1 is inner level (1)
	} sdt_sym_t;
	typedef struct packed {
		logic [15:0] pauseLimit;
		logic [6:0] syncLimit;
		logic [15:0] highLimit;
		logic [15:0] lowLimit;
		logic [15:0] noiseLimit;
		logic [15:0] unitLevel;
		logic [15:0] gainTarget;
		logic [7:0] modes;
		logic [3:0] peakDelay;
	} sdt_cfg_t;
endpackage : sdt_pkg

// *** verilog/sdt_symbol_detector.sv ***
// symbol detector thresholds, slicing, output selection and receive fifo
`timescale 1ns/1ps

// ---------------------------------------------------------------
// receive symbol fifo
// ---------------------------------------------------------------
module sdt_fifo
	import sdt_pkg::*;
#(
	parameter int WIDTH = 2,
	parameter int DEPTH = 8
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;
	logic [AW-1:0] next_wrPtr;
	logic [AW-1:0] next_rdPtr;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	// handshake and pointer update
	always_comb
	begin
		inReady = (count != DEPTH[AW:0]);
		outValid = (count != '0);
		outData = mem[rdPtr];
		push = inValid && inReady;
		pop = outValid && outReady;
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		if (push)
			next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
		if (pop)
			next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
		next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	// pointer registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
		end
	end

	// storage, no reset needed
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wrPtr] <= inData;
	end
endmodule : sdt_fifo

// ---------------------------------------------------------------
// symbol detector top
// ---------------------------------------------------------------
module sdt_symbol_detector
	import sdt_pkg::*;
#(
	parameter int PEAK_DEPTH = 16,
	parameter int FIFO_DEPTH = 8
)(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// microprocessor register port
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// receive path, one symbol per accepted strobe
	input wire logic symValid,
	output logic symReady,
	input wire logic [15:0] rxSample,
	input wire logic [15:0] predictorCorrection,
	output logic predictorPaused,
	output logic predictorCoefUpdate,
	output logic [17:0] slicerError,
	output logic [17:0] scaledSymbol,
	// peak detector and scrambler
	input wire logic peakCriteriaMet,
	input wire sdt_sym_t peakSymbol,
	input wire sdt_sym_t scramblerSymbol,
	input wire sdt_sym_t txLoopbackSymbol,
	output logic scramblerTwoBits,
	output sdt_sym_t scramblerOut,
	// scrambler sync test
	input wire logic autoSyncEnable,
	input wire logic [7:0] matchCount,
	output logic syncPass,
	// meters
	input wire logic meterValid,
	input wire logic [15:0] remoteLevelMeter,
	input wire logic [15:0] noiseMeter,
	output logic [2:0] alarmFlags,
	// gain loop
	input wire logic gainLoopErrorSelect,
	input wire logic [15:0] gainOutput,
	output logic [17:0] gainLoopError,
	// decision feedback path
	output sdt_sym_t feedbackSymbol,
	// channel unit receive interface
	output logic cuRxValid,
	input wire logic cuRxReady,
	output sdt_sym_t cuRxSymbol
);
	sdt_cfg_t cfg;
	sdt_cfg_t next_cfg;
	logic [2:0] irqSource;
	logic [2:0] next_irqSource;
	logic [7:0] next_regRdData;
	logic [2:0] pauseCount;
	logic [2:0] next_pauseCount;
	sdt_sym_t peakLine [PEAK_DEPTH];
	logic peakMetLine [PEAK_DEPTH];
	sdt_sym_t next_feedback;
	sdt_sym_t next_scrOut;
	sdt_sym_t sliced;
	sdt_sym_t detected;
	sdt_sym_t cuSel;
	logic [17:0] next_slicerError;
	logic [17:0] next_scaled;
	logic [17:0] next_gainError;
	logic [17:0] slicerIn;
	logic [17:0] absError;
	logic [17:0] levelTwice;
	logic [17:0] slicerAbs;
	logic [17:0] corrUsed;
	logic symAccept;
	logic exceed;
	logic fifoInReady;
	logic twoLevel;
	logic next_syncPass;

	// one byte into a two-byte register
	function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hiHalf,
		input logic [7:0] data);
		put_byte = hiHalf ? {data, old[7:0]} : {old[15:8], data};
	endfunction : put_byte

	// is the address either byte of the two-byte register at base
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] base);
		hits = (addr[7:1] == base[7:1]);
	endfunction : hits

	// absolute value at 18 bits
	function automatic logic [17:0] abs18(input logic [17:0] v);
		abs18 = v[17] ? 18'(-v) : v;
	endfunction : abs18

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------
	// writes, reads and alarm flags; set beats a write-one clear
	always_comb
	begin
		next_cfg = cfg;
		next_regRdData = regRdData;
		next_irqSource = irqSource;
		if (regWrite)
		begin
			if (regAddr == ADDR_IRQ_SOURCE)
				next_irqSource = irqSource & ~regWrData[2:0];
			else if (hits(regAddr, ADDR_PAUSE_LIMIT))
				next_cfg.pauseLimit = put_byte(cfg.pauseLimit, regAddr[0], regWrData);
			else if (regAddr == ADDR_SYNC_LIMIT)
				next_cfg.syncLimit = regWrData[6:0];
			else if (hits(regAddr, ADDR_HIGH_LIMIT))
				next_cfg.highLimit = put_byte(cfg.highLimit, regAddr[0], regWrData);
			else if (hits(regAddr, ADDR_LOW_LIMIT))
				next_cfg.lowLimit = put_byte(cfg.lowLimit, regAddr[0], regWrData);
			else if (hits(regAddr, ADDR_NOISE_LIMIT))
				next_cfg.noiseLimit = put_byte(cfg.noiseLimit, regAddr[0], regWrData);
			else if (hits(regAddr, ADDR_UNIT_LEVEL))
				next_cfg.unitLevel = put_byte(cfg.unitLevel, regAddr[0], regWrData);
			else if (hits(regAddr, ADDR_GAIN_TARGET))
				next_cfg.gainTarget = put_byte(cfg.gainTarget, regAddr[0], regWrData);
			else if (regAddr == ADDR_MODE_CONTROL)
				next_cfg.modes = regWrData;
			else if (regAddr == ADDR_PEAK_DELAY)
				next_cfg.peakDelay = regWrData[3:0];
		end
		// signed meter compares, flags are sticky
		if (meterValid && ($signed(remoteLevelMeter) > $signed(cfg.highLimit)))
			next_irqSource[FLAG_LEVEL_HIGH] = 1'b1;
		if (meterValid && ($signed(remoteLevelMeter) < $signed(cfg.lowLimit)))
			next_irqSource[FLAG_LEVEL_LOW] = 1'b1;
		if (meterValid && ($signed(noiseMeter) > $signed(cfg.noiseLimit)))
			next_irqSource[FLAG_LOW_SNR] = 1'b1;
		if (regRead)
		begin
			if (regAddr == ADDR_IRQ_SOURCE)
				next_regRdData = {5'h00, irqSource};
			else if (hits(regAddr, ADDR_PAUSE_LIMIT))
				next_regRdData = regAddr[0] ? cfg.pauseLimit[15:8] : cfg.pauseLimit[7:0];
			else if (regAddr == ADDR_SYNC_LIMIT)
				next_regRdData = {1'b0, cfg.syncLimit};
			else if (hits(regAddr, ADDR_HIGH_LIMIT))
				next_regRdData = regAddr[0] ? cfg.highLimit[15:8] : cfg.highLimit[7:0];
			else if (hits(regAddr, ADDR_LOW_LIMIT))
				next_regRdData = regAddr[0] ? cfg.lowLimit[15:8] : cfg.lowLimit[7:0];
			else if (hits(regAddr, ADDR_NOISE_LIMIT))
				next_regRdData = regAddr[0] ? cfg.noiseLimit[15:8] : cfg.noiseLimit[7:0];
			else if (hits(regAddr, ADDR_UNIT_LEVEL))
				next_regRdData = regAddr[0] ? cfg.unitLevel[15:8] : cfg.unitLevel[7:0];
			else if (hits(regAddr, ADDR_GAIN_TARGET))
				next_regRdData = regAddr[0] ? cfg.gainTarget[15:8] : cfg.gainTarget[7:0];
			else if (regAddr == ADDR_MODE_CONTROL)
				next_regRdData = cfg.modes;
			else if (regAddr == ADDR_PEAK_DELAY)
				next_regRdData = {4'h0, cfg.peakDelay};
			else
				next_regRdData = 8'h00;
		end
	end

	// register file state
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cfg <= '{RESET_WORD, 7'h00, RESET_WORD, RESET_WORD, RESET_WORD, RESET_WORD,
				RESET_WORD, RESET_BYTE, 4'h0};
			irqSource <= 3'h0;
			regRdData <= RESET_BYTE;
		end
		else
		begin
			cfg <= next_cfg;
			irqSource <= next_irqSource;
			regRdData <= next_regRdData;
		end
	end

	assign alarmFlags = irqSource;

	// ---------------------------------------------------------------
	// slicer, pause and detector
	// ---------------------------------------------------------------
	assign twoLevel = cfg.modes[TWO_LEVEL_BIT];
	assign symReady = fifoInReady;
	assign symAccept = symValid && fifoInReady;
	assign predictorPaused = (pauseCount != 3'h0);
	assign predictorCoefUpdate = symAccept;

	// slicing and error forming for the symbol now at the input
	always_comb
	begin
		corrUsed = predictorPaused ? 18'h00000 : {{2{predictorCorrection[15]}},
			predictorCorrection};
		slicerIn = {{2{rxSample[15]}}, rxSample} - corrUsed;
		slicerAbs = abs18(slicerIn);
		levelTwice = {1'b0, cfg.unitLevel, 1'b0};
		sliced.sign = !slicerIn[17];
		sliced.mag = twoLevel ? 1'b0 : (slicerAbs <= levelTwice);
		// the delayed peak decision overrides the slicer when its criteria hold
		if (cfg.modes[PEAK_ENABLE_BIT] && peakMetLine[cfg.peakDelay])
			detected = peakLine[cfg.peakDelay];
		else
			detected = sliced;
		next_scaled = detected.mag ? {2'b00, cfg.unitLevel} : 18'(3 * cfg.unitLevel);
		if (!detected.sign)
			next_scaled = 18'(-next_scaled);
		next_slicerError = slicerIn - next_scaled;
		absError = abs18(next_slicerError);
		exceed = absError > {2'b00, cfg.pauseLimit};
		next_pauseCount = pauseCount;
		if (symAccept)
		begin
			if (exceed)
				next_pauseCount = PAUSE_SYMBOLS;
			else if (pauseCount != 3'h0)
				next_pauseCount = pauseCount - 3'h1;
		end
		// scrambler magnitude held at zero in two-level mode
		next_scrOut.sign = scramblerSymbol.sign;
		next_scrOut.mag = twoLevel ? 1'b0 : scramblerSymbol.mag;
		next_feedback = cfg.modes[FEEDBACK_SELECT_BIT] ? next_scrOut : detected;
		next_gainError = gainLoopErrorSelect ? next_slicerError
			: abs18({{2{gainOutput[15]}}, gainOutput}) - {2'b00, cfg.gainTarget};
		next_syncPass = autoSyncEnable && (matchCount > {1'b0, cfg.syncLimit});
	end

	// scrambler steps once per symbol in two-level mode, twice otherwise
	assign scramblerTwoBits = !twoLevel;

	// per-symbol output registers, sync pass registered every clock
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pauseCount <= 3'h0;
			slicerError <= 18'h00000;
			scaledSymbol <= 18'h00000;
			gainLoopError <= 18'h00000;
			feedbackSymbol <= '0;
			scramblerOut <= '0;
			syncPass <= 1'b0;
		end
		else
		begin
			pauseCount <= next_pauseCount;
			syncPass <= next_syncPass;
			if (symAccept)
			begin
				slicerError <= next_slicerError;
				scaledSymbol <= next_scaled;
				gainLoopError <= next_gainError;
				feedbackSymbol <= next_feedback;
				scramblerOut <= next_scrOut;
			end
		end
	end

	// peak detector input delay line; tap 0 already lags the input by one symbol
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < PEAK_DEPTH; i++)
			begin
				peakLine[i] <= '0;
				peakMetLine[i] <= 1'b0;
			end
		end
		else if (symAccept)
		begin
			peakLine[0] <= peakSymbol;
			peakMetLine[0] <= peakCriteriaMet;
			for (int i = 1; i < PEAK_DEPTH; i++)
			begin
				peakLine[i] <= peakLine[i-1];
				peakMetLine[i] <= peakMetLine[i-1];
			end
		end
	end

	// ---------------------------------------------------------------
	// channel unit output select and fifo
	// ---------------------------------------------------------------
	always_comb
	begin
		case (sdt_outsel_t'(cfg.modes[OUT_SELECT_LSB +: 2]))
			OUT_TX_LOOPBACK: cuSel = txLoopbackSymbol;
			OUT_SCRAMBLER: cuSel = next_scrOut;
			default: cuSel = next_feedback;
		endcase
	end

	sdt_fifo #(
		.WIDTH(2),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.inValid(symValid),
		.inReady(fifoInReady),
		.inData(cuSel),
		.outValid(cuRxValid),
		.outReady(cuRxReady),
		.outData(cuRxSymbol)
	);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_exceed;
		symAccept && exceed;
	endsequence
	sequence s_meterHigh;
		meterValid && ($signed(remoteLevelMeter) > $signed(cfg.highLimit));
	endsequence

	a_pause_load: assert property (s_exceed |=> pauseCount == 3'h5)
		else $error("pause count not loaded to five");
	a_pause_zero: assert property (predictorPaused |-> corrUsed == 18'h00000)
		else $error("correction not zeroed in pause");
	a_pause_end: assert property ($fell(predictorPaused) |-> $past(pauseCount) == 3'h1)
		else $error("pause ended early");
	a_sync_gate: assert property (syncPass |-> $past(autoSyncEnable))
		else $error("sync pass without auto sync");
	a_sync_pass: assert property (autoSyncEnable && matchCount > {1'b0, cfg.syncLimit}
		|=> syncPass)
		else $error("sync pass missing");
	a_level_high: assert property (s_meterHigh |=> irqSource[FLAG_LEVEL_HIGH])
		else $error("high level flag not set");
	a_level_low: assert property (meterValid && ($signed(remoteLevelMeter)
		< $signed(cfg.lowLimit)) |=> irqSource[FLAG_LEVEL_LOW])
		else $error("low level flag not set");
	a_noise_flag: assert property (meterValid && ($signed(noiseMeter)
		> $signed(cfg.noiseLimit)) |=> irqSource[FLAG_LOW_SNR])
		else $error("low noise ratio flag not set");
	a_scr_mag: assert property (symAccept && twoLevel |=> !scramblerOut.mag)
		else $error("scrambler magnitude not zero");
	a_gain_mode: assert property (symAccept && gainLoopErrorSelect
		|=> gainLoopError == slicerError)
		else $error("gain error not equalizer error");
endmodule : sdt_symbol_detector

// *** verif/sdt_cu_sink.sv ***
// channel unit receive side model that drains the detector fifo
`timescale 1ns/1ps

// ---------------------------------------------------------------
// receive sink with stall control
// ---------------------------------------------------------------
module sdt_cu_sink
	import sdt_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// bench control
	input wire logic stall,
	// channel unit receive interface
	input wire logic cuRxValid,
	output logic cuRxReady,
	input wire sdt_sym_t cuRxSymbol,
	// capture log
	output logic [4:0] count
);
	sdt_sym_t got [32];

	// ready follows stall one edge later, symbols logged on handshake
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cuRxReady <= 1'b0;
			count <= 5'h00;
		end
		else
		begin
			cuRxReady <= !stall;
			if (cuRxValid && cuRxReady)
			begin
				got[count] <= cuRxSymbol;
				count <= count + 5'h01;
			end
		end
	end
endmodule : sdt_cu_sink

// *** verif/tb_sdt_symbol_detector.sv ***
// self-checking bench for the symbol detector thresholds block
`timescale 1ns/1ps

module tb_sdt_symbol_detector
	import sdt_pkg::*;
;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic core_clk, rst_n, regWrite, regRead, symValid, peakCriteriaMet;
	logic autoSyncEnable, meterValid, gainLoopErrorSelect, stall, coefSeen;
	logic symReady, predictorPaused, predictorCoefUpdate, scramblerTwoBits;
	logic syncPass, cuRxValid, cuRxReady;
	logic [7:0] regAddr, regWrData, regRdData, matchCount;
	logic [15:0] rxSample, predictorCorrection, remoteLevelMeter, noiseMeter, gainOutput;
	logic [17:0] slicerError, scaledSymbol, gainLoopError;
	logic [2:0] alarmFlags;
	logic [4:0] sinkCount;
	sdt_sym_t peakSymbol, scramblerSymbol, txLoopbackSymbol, scramblerOut;
	sdt_sym_t feedbackSymbol, cuRxSymbol;
	int failCount, cmpCount, cycles;

	// design and receive sink
	sdt_symbol_detector #(.PEAK_DEPTH(16), .FIFO_DEPTH(8)) DUT (.*);
	sdt_cu_sink sink (.core_clk(core_clk), .rst_n(rst_n), .stall(stall),
		.cuRxValid(cuRxValid), .cuRxReady(cuRxReady), .cuRxSymbol(cuRxSymbol),
		.count(sinkCount));

	// 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// cycle ceiling against hangs
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failCount++;
			reportAndStop();
		end
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic reportAndStop;
		if (failCount == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : reportAndStop

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			failCount++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask : reg_wr

	// low byte at the even address, high byte next
	task automatic reg_wr16(input logic [7:0] a, input logic [15:0] v);
		reg_wr(a, v[7:0]);
		reg_wr(a + 8'h01, v[15:8]);
	endtask : reg_wr16

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		d = regRdData;
	endtask : reg_rd

	// offer one symbol and hold it until taken
	task automatic send_sym(input logic [15:0] s, input logic [15:0] c);
		logic ok;
		@(posedge core_clk);
		symValid <= 1'b1;
		rxSample <= s;
		predictorCorrection <= c;
		coefSeen = 1'b0;
		do
		begin
			#1;
			ok = symReady;
			coefSeen = coefSeen | (ok & predictorCoefUpdate);
			@(posedge core_clk);
		end
		while (!ok);
		symValid <= 1'b0;
		#1;
		coefSeen = coefSeen | predictorCoefUpdate;
	endtask : send_sym

	// symbol number n as logged by the sink
	task automatic take(input logic [4:0] n, output sdt_sym_t s);
		for (int k = 0; k < 10 && sinkCount == n; k++)
		begin
			@(posedge core_clk);
			#1;
		end
		s = sink.got[n];
	endtask : take

	task automatic setup(input logic [7:0] mode, input logic [15:0] lim);
		reg_wr16(ADDR_UNIT_LEVEL, 16'h0100);
		reg_wr16(ADDR_PAUSE_LIMIT, lim);
		reg_wr(ADDR_MODE_CONTROL, mode);
		reg_wr(ADDR_PEAK_DELAY, 8'h00);
	endtask : setup

	function automatic logic [7:0] reg_mask(input logic [7:0] a);
		case (a)
			8'h2e: return 8'h7f;
			8'h2f, 8'h3c: return 8'h00;
			8'h3b: return 8'h0f;
			default: return 8'hff;
		endcase
	endfunction : reg_mask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		logic [7:0] d;
		for (int i = 0; i < 17; i++)
		begin
			reg_rd((i == 16) ? ADDR_IRQ_SOURCE : 8'(8'h2c + i), d);
			check(d, 8'h00);
		end
		for (int i = 0; i < 17; i++)
			reg_wr(8'(8'h2c + i), 8'(8'h2c + i) ^ 8'ha5);
		for (int i = 0; i < 17; i++)
		begin
			reg_rd(8'(8'h2c + i), d);
			check(d, (8'(8'h2c + i) ^ 8'ha5) & reg_mask(8'(8'h2c + i)));
		end
	endtask : t_regs

	task automatic t_pause;
		setup(8'h00, 16'h0040);
		send_sym(16'h0150, 16'h0000);
		check(slicerError, 18'h00050);
		for (int i = 0; i < 5; i++)
		begin
			check(predictorPaused, 1'b1);
			send_sym(16'h0100, 16'h0080);
			check(slicerError, 18'h00000);
			check(coefSeen, 1'b1);
		end
		check(predictorPaused, 1'b0);
		send_sym(16'h0100, 16'h0080);
		check(slicerError, 18'h3ff80);
		check(predictorPaused, 1'b1);
	endtask : t_pause

	task automatic t_slicer;
		logic [15:0] smp [7] = '{16'h0350, 16'h0201, 16'h0200, 16'h0150, 16'hfeb0,
			16'hfe00, 16'hfcb0};
		logic [17:0] scl [7] = '{18'h00300, 18'h00300, 18'h00100, 18'h00100, 18'h3ff00,
			18'h3ff00, 18'h3fd00};
		logic [1:0] sym [7] = '{2'b10, 2'b10, 2'b11, 2'b11, 2'b01, 2'b01, 2'b00};
		setup(8'h00, 16'h7fff);
		for (int i = 0; i < 7; i++)
		begin
			send_sym(smp[i], 16'h0000);
			check(scaledSymbol, scl[i]);
			check(feedbackSymbol, sym[i]);
			check(scramblerOut, scramblerSymbol);
		end
		check(scramblerTwoBits, 1'b1);
		setup(8'h08, 16'h7fff);
		@(posedge core_clk);
		scramblerSymbol <= 2'b11;
		send_sym(16'h0150, 16'h0000);
		check(feedbackSymbol, 2'b10);
		check(scramblerOut, 2'b10);
		send_sym(16'hfcb0, 16'h0000);
		check(feedbackSymbol, 2'b00);
		check(scramblerTwoBits, 1'b0);
		@(posedge core_clk);
		scramblerSymbol <= 2'b01;
	endtask : t_slicer

	task automatic t_outsel;
		logic [4:0] n;
		sdt_sym_t s;
		for (int f = 0; f < 2; f++)
			for (int c = 0; c < 4; c++)
			begin
				setup(8'((c << 5) | (f << 4)), 16'h7fff);
				n = sinkCount;
				send_sym(16'h0350, 16'h0000);
				check(feedbackSymbol, f ? 2'b01 : 2'b10);
				take(n, s);
				check(s, (c == 1) ? 2'b11 : (c == 2 || f == 1) ? 2'b01 : 2'b10);
			end
	endtask : t_outsel

	task automatic t_peak;
		setup(8'h80, 16'h7fff);
		reg_wr(ADDR_PEAK_DELAY, 8'h02);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge core_clk);
			peakCriteriaMet <= (i == 2);
			send_sym(16'h0350, 16'h0000);
			check(feedbackSymbol, (i == 5) ? 2'b00 : 2'b10);
		end
		reg_wr(ADDR_PEAK_DELAY, 8'h00);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge core_clk);
			peakCriteriaMet <= (i == 0);
			send_sym(16'h0350, 16'h0000);
			check(feedbackSymbol, (i == 1) ? 2'b00 : 2'b10);
		end
	endtask : t_peak

	task automatic t_sync;
		logic [8:0] tv [4] = '{9'h110, 9'h111, 9'h011, 9'h100};
		logic ex [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
		reg_wr(ADDR_SYNC_LIMIT, 8'h10);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge core_clk);
			autoSyncEnable <= tv[i][8];
			matchCount <= tv[i][7:0];
			@(posedge core_clk);
			#1;
			check(syncPass, ex[i]);
		end
	endtask : t_sync

	task automatic t_alarms;
		logic [15:0] lv [6] = '{16'h0100, 16'h0080, 16'h0101, 16'h007f, 16'hffff, 16'h0100};
		logic [15:0] nv [6] = '{16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0201};
		logic [2:0] ex [6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h4};
		logic [7:0] d;
		reg_wr16(ADDR_HIGH_LIMIT, 16'h0100);
		reg_wr16(ADDR_LOW_LIMIT, 16'h0080);
		reg_wr16(ADDR_NOISE_LIMIT, 16'h0200);
		for (int i = 0; i < 6; i++)
		begin
			reg_wr(ADDR_IRQ_SOURCE, 8'h07);
			@(posedge core_clk);
			meterValid <= 1'b1;
			remoteLevelMeter <= lv[i];
			noiseMeter <= nv[i];
			@(posedge core_clk);
			meterValid <= 1'b0;
			@(posedge core_clk);
			#1;
			check(alarmFlags, ex[i]);
			reg_rd(ADDR_IRQ_SOURCE, d);
			check(d, {5'h00, ex[i]});
		end
		// a clear in the same cycle as a new event leaves the flag set
		@(posedge core_clk);
		meterValid <= 1'b1;
		regWrite <= 1'b1;
		regAddr <= ADDR_IRQ_SOURCE;
		regWrData <= 8'h07;
		@(posedge core_clk);
		meterValid <= 1'b0;
		regWrite <= 1'b0;
		@(posedge core_clk);
		#1;
		check(alarmFlags, 3'h4);
	endtask : t_alarms

	task automatic t_gain;
		setup(8'h00, 16'h7fff);
		reg_wr16(ADDR_GAIN_TARGET, 16'h0100);
		@(posedge core_clk);
		gainOutput <= 16'hfe80;
		send_sym(16'h0350, 16'h0000);
		check(gainLoopError, 18'h00080);
		@(posedge core_clk);
		gainOutput <= 16'h0050;
		send_sym(16'h0350, 16'h0000);
		check(gainLoopError, 18'h3ff50);
		@(posedge core_clk);
		gainLoopErrorSelect <= 1'b1;
		send_sym(16'h0350, 16'h0000);
		check(gainLoopError, 18'h00050);
		reg_wr16(ADDR_GAIN_TARGET, 16'h0200);
		send_sym(16'h0350, 16'h0000);
		check(gainLoopError, 18'h00050);
	endtask : t_gain

	// fill the fifo against a stalled sink, then drain it
	task automatic t_fifo;
		logic [4:0] n;
		setup(8'h00, 16'h7fff);
		@(posedge core_clk);
		stall <= 1'b1;
		n = sinkCount;
		@(posedge core_clk);
		symValid <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rxSample <= i[0] ? 16'hfcb0 : 16'h0350;
			@(posedge core_clk);
		end
		rxSample <= 16'h0150;
		@(posedge core_clk);
		symValid <= 1'b0;
		stall <= 1'b0;
		#1;
		check(symReady, 1'b0);
		check(cuRxValid, 1'b1);
		for (int k = 0; k < 40 && cuRxValid; k++)
		begin
			@(posedge core_clk);
			#1;
		end
		check(sinkCount, 5'(n + 5'h08));
		for (int i = 0; i < 8; i++)
			check(sink.got[5'(n + i)], i[0] ? 2'b00 : 2'b10);
	endtask : t_fifo

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		failCount = 0;
		cmpCount = 0;
		cycles = 0;
		rst_n = 1'b0;
		{regWrite, regRead, symValid, peakCriteriaMet, stall} = 5'h00;
		{autoSyncEnable, meterValid, gainLoopErrorSelect} = 3'h0;
		{regAddr, regWrData, matchCount} = 24'h000000;
		{rxSample, predictorCorrection, remoteLevelMeter} = 48'h000000000000;
		{noiseMeter, gainOutput} = 32'h00000000;
		peakSymbol = 2'b00;
		scramblerSymbol = 2'b01;
		txLoopbackSymbol = 2'b11;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		t_regs();
		t_pause();
		t_slicer();
		t_outsel();
		t_peak();
		t_sync();
		t_alarms();
		t_gain();
		t_fifo();
		reportAndStop();
	end
endmodule : tb_sdt_symbol_detector
